// ==== logic/pcc_capture.sv ====
// parallel camera capture: pin sampling, sync handling, packing, buffering, dma request
// Functional notes
// R01 - widths 8, 10, 12 or 14 lines; one sample per pixel clock
// R02 - 8-bit width reads only lines 7:0, upper six ignored
// R03 - 8-bit: first byte in bits 7:0, fourth in 31:24, word per four samples
// R04 - 10-bit sample in low ten bits of half-word, bits 15:10 zero
// R05 - 12-bit sample in low twelve bits of half-word, bits 15:12 zero
// R06 - 14-bit sample in low fourteen bits of half-word, bits 15:14 zero
// R07 - wide widths: earlier sample lower half, next upper, word per two samples
// R08 - packed words pass through a four-word fifo
// R09 - overrun or sync error flushes buffer and waits for next frame start
// R10 - each completed output word raises a dma request
// R11 - embedded sync uses eight lines and clock, ignores sync inputs
// R12 - every camera-side line is an input
// R13 - hardware sync drops samples while either sync is at its active level
// R14 - sample on the configured pixel clock edge
// R15 - system clock at least 2.5 times the pixel clock
// R16 - delimiters are FF 00 00 then event byte; data never 00 or FF
// R17 - camera pins cross into mclk through synchronisers before use
// R18 - reset or disable clears partial word, fifo and dma request
module pcc_capture
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic camera_pixel_clock,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic [PCC_LINES-1:0] camera_pixel_lines,
  input wire pcc_cfg_t cfg,
  input wire pcc_codes_t codes,
  input wire logic dma_ack,
  output logic [PCC_WORD-1:0] captured_pixel_word,
  output logic dma_request,
  output logic capture_error,
  output logic frame_wait
);

  // ==========================================================================
  // half-word formatting for the wide widths
  function automatic logic [PCC_HALF-1:0] pcc_half(input pcc_width_t w,
                                                   input logic [PCC_LINES-1:0] d);
    logic [PCC_HALF-1:0] h;
    h = '0;
    unique case (w)
      PCC_W10: h[PCC_W10_BITS-1:0] = d[PCC_W10_BITS-1:0]; // R04
      PCC_W12: h[PCC_W12_BITS-1:0] = d[PCC_W12_BITS-1:0]; // R05
      PCC_W14: h[PCC_W14_BITS-1:0] = d[PCC_W14_BITS-1:0]; // R06
      PCC_W8: h[PCC_BYTE-1:0] = d[PCC_BYTE-1:0];
    endcase
    return h;
  endfunction : pcc_half

  // ==========================================================================
  // pin synchronisers
  pcc_pins_t pins_in;
  pcc_pins_t s1_reg;
  pcc_pins_t s1_next;
  pcc_pins_t s2_reg;
  pcc_pins_t s2_next;
  logic pclk_d_reg;
  logic pclk_d_next;

  // R12
  assign pins_in = '{lines: camera_pixel_lines, line_sync: line_sync_in,
                     frame_sync: frame_sync_in, pclk: camera_pixel_clock};

  always_comb
  begin
    s1_next = pins_in; // R17
    s2_next = s1_reg; // R17
    pclk_d_next = s2_reg.pclk;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      pclk_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      pclk_d_reg <= pclk_d_next;
    end
  end

  // data changes on the other edge, so s2 lines are settled at the chosen edge;
  // this only holds while mclk keeps the 2.5x margin over the pixel clock
  logic sample_tick;
  assign sample_tick = cfg.falling ? (pclk_d_reg && !s2_reg.pclk) // R14 R15
                                   : (!pclk_d_reg && s2_reg.pclk); // R14

  // ==========================================================================
  // sync tracking and packing
  logic [1:0] hdr_reg;
  logic [1:0] hdr_next;
  logic in_frame_reg;
  logic in_frame_next;
  logic in_line_reg;
  logic in_line_next;
  logic wait_reg;
  logic wait_next;
  logic frame_act_d_reg;
  logic frame_act_d_next;
  logic [PCC_WORD-1:0] pack_reg;
  logic [PCC_WORD-1:0] pack_next;
  logic [1:0] lane_reg;
  logic [1:0] lane_next;
  logic push_reg;
  logic push_next;
  logic [PCC_WORD-1:0] push_data_reg;
  logic [PCC_WORD-1:0] push_data_next;
  logic flush_reg;
  logic flush_next;
  logic err_reg;
  logic err_next;
  logic fifo_in_ready;

  logic [PCC_BYTE-1:0] cur_byte;
  logic frame_act;
  logic line_act;
  logic valid;
  logic fstart;
  logic serr;
  logic complete;

  always_comb
  begin
    cur_byte = s2_reg.lines[PCC_BYTE-1:0]; // R02 R11
    frame_act = (s2_reg.frame_sync == cfg.frame_pol);
    line_act = (s2_reg.line_sync == cfg.line_pol);
    valid = 1'b0;
    fstart = 1'b0;
    serr = 1'b0;
    complete = 1'b0;
    hdr_next = hdr_reg;
    in_frame_next = in_frame_reg;
    in_line_next = in_line_reg;
    wait_next = wait_reg;
    frame_act_d_next = frame_act_d_reg;
    pack_next = pack_reg;
    lane_next = lane_reg;
    push_next = 1'b0;
    push_data_next = push_data_reg;
    flush_next = 1'b0;
    err_next = 1'b0;
    if (!cfg.enable)
    begin
      hdr_next = PCC_HDR_RST; // R18
      in_frame_next = 1'b0;
      in_line_next = 1'b0;
      wait_next = 1'b1;
      frame_act_d_next = 1'b0;
      pack_next = PCC_WORD_RST; // R18
      lane_next = PCC_LANE_RST;
      flush_next = 1'b1; // R18
    end
    else if (sample_tick)
    begin // R01
      if (cfg.embedded)
      begin // R11
        if (hdr_reg == PCC_HDR_CODE)
        begin // R16
          hdr_next = PCC_HDR_RST;
          if (cur_byte == codes.frame_start)
          begin
            in_frame_next = 1'b1;
            in_line_next = 1'b0;
            fstart = 1'b1;
          end
          else if (cur_byte == codes.line_start)
            in_line_next = 1'b1;
          else if (cur_byte == codes.line_end)
            in_line_next = 1'b0;
          else if (cur_byte == codes.frame_end)
          begin
            in_frame_next = 1'b0;
            in_line_next = 1'b0;
          end
          else
            serr = 1'b1; // R09
        end
        else if (cur_byte == PCC_DELIM_FF)
          hdr_next = 2'h1; // R16
        else if (cur_byte == PCC_DELIM_00)
          hdr_next = (hdr_reg == PCC_HDR_RST) ? PCC_HDR_RST : 2'(hdr_reg + 1'b1); // R16
        else
        begin
          hdr_next = PCC_HDR_RST;
          valid = in_frame_reg && in_line_reg;
        end
      end
      else
      begin
        valid = !frame_act && !line_act; // R13
        fstart = frame_act_d_reg && !frame_act;
        frame_act_d_next = frame_act;
      end
      if (fstart && wait_reg)
      begin
        wait_next = 1'b0;
        pack_next = PCC_WORD_RST;
        lane_next = PCC_LANE_RST;
      end
      else if (valid && !wait_reg)
      begin
        if (cfg.width == PCC_W8)
        begin
          pack_next[lane_reg*PCC_BYTE +: PCC_BYTE] = cur_byte; // R03
          complete = (lane_reg == PCC_LAST_BYTE_LANE); // R03
        end
        else
        begin
          pack_next[lane_reg[0]*PCC_HALF +: PCC_HALF] = pcc_half(cfg.width, s2_reg.lines); // R07
          complete = (lane_reg == PCC_LAST_HALF_LANE); // R07
        end
        lane_next = complete ? PCC_LANE_RST : 2'(lane_reg + 1'b1);
      end
      if (complete)
      begin
        if (fifo_in_ready)
        begin
          push_next = 1'b1; // R08
          push_data_next = pack_next;
        end
        else
          serr = 1'b1; // R09
      end
      if (serr)
      begin
        wait_next = 1'b1; // R09
        flush_next = 1'b1; // R09
        err_next = 1'b1;
        pack_next = PCC_WORD_RST;
        lane_next = PCC_LANE_RST;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      hdr_reg <= PCC_HDR_RST;
      in_frame_reg <= 1'b0;
      in_line_reg <= 1'b0;
      wait_reg <= 1'b1;
      frame_act_d_reg <= 1'b0;
      pack_reg <= PCC_WORD_RST;
      lane_reg <= PCC_LANE_RST;
      push_reg <= 1'b0;
      push_data_reg <= PCC_WORD_RST;
      flush_reg <= 1'b1;
      err_reg <= 1'b0;
    end
    else
    begin
      hdr_reg <= hdr_next;
      in_frame_reg <= in_frame_next;
      in_line_reg <= in_line_next;
      wait_reg <= wait_next;
      frame_act_d_reg <= frame_act_d_next;
      pack_reg <= pack_next;
      lane_reg <= lane_next;
      push_reg <= push_next;
      push_data_reg <= push_data_next;
      flush_reg <= flush_next;
      err_reg <= err_next;
    end
  end

  // ==========================================================================
  // fifo, two-entry buffer and output word register
  logic fifo_out_valid;
  logic [PCC_WORD-1:0] fifo_out_data;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [PCC_WORD-1:0] buf_out_data;
  logic out_take;
  logic [PCC_WORD-1:0] word_reg;
  logic [PCC_WORD-1:0] word_next;
  logic req_reg;
  logic req_next;

  pcc_fifo #(.WIDTH(PCC_WORD), .DEPTH(PCC_FIFO_DEPTH)) u_fifo ( // R08
    .mclk(mclk),
    .nrst(nrst),
    .flush(flush_reg),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(push_data_reg),
    .out_valid(fifo_out_valid),
    .out_ready(buf_in_ready),
    .out_data(fifo_out_data)
  );

  // the dma stalling here backs up through the buffer into the fifo
  pcc_fifo #(.WIDTH(PCC_WORD), .DEPTH(PCC_BUF_DEPTH)) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .flush(flush_reg),
    .in_valid(fifo_out_valid),
    .in_ready(buf_in_ready),
    .in_data(fifo_out_data),
    .out_valid(buf_out_valid),
    .out_ready(out_take),
    .out_data(buf_out_data)
  );

  always_comb
  begin
    out_take = buf_out_valid && (!req_reg || dma_ack) && !flush_reg;
    word_next = word_reg;
    req_next = req_reg;
    if (flush_reg)
      req_next = 1'b0; // R18 R09
    else if (out_take)
    begin
      word_next = buf_out_data;
      req_next = 1'b1; // R10
    end
    else if (dma_ack)
      req_next = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      word_reg <= PCC_WORD_RST;
      req_reg <= 1'b0;
    end
    else
    begin
      word_reg <= word_next;
      req_reg <= req_next;
    end
  end

  assign captured_pixel_word = word_reg;
  assign dma_request = req_reg;
  assign capture_error = err_reg;
  assign frame_wait = wait_reg;

endmodule : pcc_capture

// ==== logic/pcc_pkg.sv ====
// constants, types and field layouts shared by the parallel camera capture design
package pcc_pkg;

  // ==========================================================================
  // widths and depths
  localparam int PCC_LINES = 14;
  localparam int PCC_BYTE = 8;
  localparam int PCC_HALF = 16;
  localparam int PCC_WORD = 32;
  localparam int PCC_FIFO_DEPTH = 4;
  localparam int PCC_BUF_DEPTH = 2;

  // ==========================================================================
  // field positions and values
  localparam int PCC_W10_BITS = 10;
  localparam int PCC_W12_BITS = 12;
  localparam int PCC_W14_BITS = 14;
  localparam logic [1:0] PCC_LAST_BYTE_LANE = 2'h3;
  localparam logic [1:0] PCC_LAST_HALF_LANE = 2'h1;
  localparam logic [1:0] PCC_HDR_CODE = 2'h3;
  localparam logic [7:0] PCC_DELIM_FF = 8'hFF;
  localparam logic [7:0] PCC_DELIM_00 = 8'h00;

  // ==========================================================================
  // reset values
  localparam logic [31:0] PCC_WORD_RST = 32'h0000_0000;
  localparam logic [1:0] PCC_LANE_RST = 2'h0;
  localparam logic [1:0] PCC_HDR_RST = 2'h0;

  // ==========================================================================
  // timing: mclk period and least mclk to pixel clock ratio, in tenths
  localparam int PCC_MCLK_PERIOD_NS = 50;
  localparam int PCC_MIN_RATIO_X10 = 25;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {PCC_W8, PCC_W10, PCC_W12, PCC_W14} pcc_width_t;

  typedef struct packed {
    logic [13:0] lines;
    logic line_sync;
    logic frame_sync;
    logic pclk;
  } pcc_pins_t;

  typedef struct packed {
    logic enable;
    pcc_width_t width;
    logic embedded;
    logic falling;
    logic line_pol;
    logic frame_pol;
  } pcc_cfg_t;

  typedef struct packed {
    logic [7:0] frame_start;
    logic [7:0] line_start;
    logic [7:0] line_end;
    logic [7:0] frame_end;
  } pcc_codes_t;

endpackage : pcc_pkg

// ==== logic/pcc_fifo.sv ====
// small register-array fifo with valid/ready on both sides and a flush
module pcc_fifo
  import pcc_pkg::*;
#(
  parameter int WIDTH = PCC_WORD,
  parameter int DEPTH = PCC_FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] rd_ptr_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic do_wr;
  logic do_rd;

  // ==========================================================================
  // pointers and fill count
  always_comb
  begin
    in_ready = (count_reg != FULL);
    out_valid = (count_reg != '0);
    out_data = mem_reg[rd_ptr_reg];
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (flush)
    begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next = '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_next = PW'(wr_ptr_reg + 1'b1);
      if (do_rd)
        rd_ptr_next = PW'(rd_ptr_reg + 1'b1);
      if (do_wr && !do_rd)
        count_next = CW'(count_reg + 1'b1);
      else if (do_rd && !do_wr)
        count_next = CW'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // ==========================================================================
  // storage, one entry per generate step
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    logic [WIDTH-1:0] entry_next;
    always_comb
    begin
      entry_next = mem_reg[i];
      if (do_wr && !flush && (wr_ptr_reg == PW'(i)))
        entry_next = in_data;
    end
    always_ff @(posedge mclk)
    begin
      if (!nrst)
        mem_reg[i] <= '0;
      else
        mem_reg[i] <= entry_next;
    end
  end

endmodule : pcc_fifo

// ==== verification/pcc_capture_checker.sv ====
// port-level assertions for the parallel camera capture block
module pcc_capture_checker
  import pcc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic camera_pixel_clock,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic [PCC_LINES-1:0] camera_pixel_lines,
  input wire pcc_cfg_t cfg,
  input wire pcc_codes_t codes,
  input wire logic dma_ack,
  input wire logic [PCC_WORD-1:0] captured_pixel_word,
  input wire logic dma_request,
  input wire logic capture_error,
  input wire logic frame_wait
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // ==========
  // helpers
  function automatic logic has_rsv(input logic [31:0] w);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++)
      r = r | (w[8*i +: 8] == 8'h00) | (w[8*i +: 8] == 8'hFF);
    return r;
  endfunction : has_rsv
  sequence s_quiet;
    frame_wait [*3] ##0 !dma_request;
  endsequence
  sequence s_flushed;
    ##[1:2] !dma_request && frame_wait;
  endsequence
  // ==========
  // assertions
  a_reset_clears:
    assert property ($rose(nrst) |-> !dma_request && frame_wait && captured_pixel_word == 32'h0)
    else $error("outputs not cleared by reset");
  a_disable_flush:
    assert property (!cfg.enable [*2] |=> !dma_request && frame_wait)
    else $error("request alive while disabled");
  a_word_holds:
    assert property (dma_request && !dma_ack && cfg.enable && !capture_error
      && !$past(capture_error) |=> dma_request && $stable(captured_pixel_word))
    else $error("word dropped without ack");
  a_error_flushes:
    assert property (capture_error |-> s_flushed)
    else $error("no flush after error");
  a_error_pulse:
    assert property (capture_error |=> !capture_error)
    else $error("error longer than one cycle");
  a_wait_quiet:
    assert property (s_quiet |=> !dma_request)
    else $error("word delivered while waiting");
  a_w10_zeros:
    assert property (dma_request && cfg.enable && cfg.width == PCC_W10 |->
      captured_pixel_word[15:10] == 6'h00 && captured_pixel_word[31:26] == 6'h00)
    else $error("upper bits set in 10 bit word");
  a_w12_zeros:
    assert property (dma_request && cfg.enable && cfg.width == PCC_W12 |->
      captured_pixel_word[15:12] == 4'h0 && captured_pixel_word[31:28] == 4'h0)
    else $error("upper bits set in 12 bit word");
  a_w14_zeros:
    assert property (dma_request && cfg.enable && cfg.width == PCC_W14 |->
      captured_pixel_word[15:14] == 2'h0 && captured_pixel_word[31:30] == 2'h0)
    else $error("upper bits set in 14 bit word");
  a_embedded_data:
    assert property (dma_request && cfg.enable && cfg.embedded |-> !has_rsv(captured_pixel_word))
    else $error("reserved byte delivered");
endmodule : pcc_capture_checker

bind pcc_capture pcc_capture_checker u_chk (
  .mclk(mclk), .nrst(nrst), .camera_pixel_clock(camera_pixel_clock),
  .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
  .camera_pixel_lines(camera_pixel_lines), .cfg(cfg), .codes(codes), .dma_ack(dma_ack),
  .captured_pixel_word(captured_pixel_word), .dma_request(dma_request),
  .capture_error(capture_error), .frame_wait(frame_wait)
);

// ==== verification/pcc_cam_model.sv ====
// behavioural camera driving pixel clock, sync and data pins
module pcc_cam_model
  import pcc_pkg::*;
(
  output logic pclk,
  output logic line_sync,
  output logic frame_sync,
  output logic [PCC_LINES-1:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fall = 1'b0;
  // every pin is driven from here, the receiver only listens
  initial
  begin
    pclk = 1'b0;
    line_sync = 1'b1;
    frame_sync = 1'b1;
    lines = 14'h0000;
  end
  task automatic set_idle(input logic f);
    fall = f;
    pclk = f;
  endtask : set_idle
  // 393 ns period, about 7.9 mclk; clock stands still between calls
  task automatic pix(input logic [13:0] d, input logic ls, input logic fs);
    #7 lines = d;
    line_sync = ls;
    frame_sync = fs;
    #100 pclk = ~fall;
    #200 pclk = fall;
    #86 lines = ~d;
  endtask : pix
  // frame sync leaves its active level while the line is still blanked
  task automatic frame_start();
    pix(14'h0000, 1'b1, 1'b1);
    pix(14'h0000, 1'b1, 1'b0);
  endtask : frame_start
  task automatic code(input logic [7:0] ev);
    pix(14'h00FF, 1'b1, 1'b1);
    pix(14'h0000, 1'b1, 1'b1);
    pix(14'h0000, 1'b1, 1'b1);
    pix({6'h00, ev}, 1'b1, 1'b1);
  endtask : code
endmodule : pcc_cam_model

// ==== verification/testbench.sv ====
// self-checking bench for the parallel camera capture block
module testbench
  import pcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic dma_ack = 1'b0;
  pcc_cfg_t cfg = '0;
  pcc_codes_t codes = '{8'h20, 8'h40, 8'h60, 8'h70};
  logic pclk;
  logic lsync;
  logic fsync;
  logic [PCC_LINES-1:0] lines;
  logic [PCC_WORD-1:0] word;
  logic req;
  logic err;
  logic fwait;
  int fails = 0;
  int checks_done = 0;
  int err_seen = 0;
  int wbits [3] = '{PCC_W10_BITS, PCC_W12_BITS, PCC_W14_BITS};
  always #25 mclk = ~mclk;
  always @(posedge mclk)
    if (err === 1'b1)
      err_seen++;
  pcc_capture u_dut (
    .mclk(mclk), .nrst(nrst), .camera_pixel_clock(pclk), .line_sync_in(lsync),
    .frame_sync_in(fsync), .camera_pixel_lines(lines), .cfg(cfg), .codes(codes),
    .dma_ack(dma_ack), .captured_pixel_word(word), .dma_request(req),
    .capture_error(err), .frame_wait(fwait)
  );
  pcc_cam_model u_cam (.pclk(pclk), .line_sync(lsync), .frame_sync(fsync), .lines(lines));
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic take(input logic [31:0] exp, input string nm);
    int n = 0;
    // start on an edge so that the acknowledge below always changes at a rising edge
    @(posedge mclk);
    while (req !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    chk("request", 32'(req), 32'h1);
    chk(nm, word, exp);
    dma_ack <= 1'b1;
    @(posedge mclk);
    dma_ack <= 1'b0;
    @(posedge mclk);
  endtask : take
  task automatic setcfg(input pcc_width_t w, input logic e, input logic f);
    @(posedge mclk);
    cfg.enable <= 1'b0;
    repeat (4) @(posedge mclk);
    u_cam.set_idle(f);
    cfg <= '{1'b1, w, e, f, 1'b1, 1'b1};
    repeat (4) @(posedge mclk);
  endtask : setcfg
  // ==========
  // scenarios
  task automatic t_w8();
    setcfg(PCC_W8, 1'b0, 1'b0);
    u_cam.frame_start();
    for (int i = 0; i < 8; i++)
      u_cam.pix({6'h2A, 8'(8'h11 * (i + 1))}, 1'b0, 1'b0);
    take(32'h44332211, "w8 word0");
    take(32'h88776655, "w8 word1");
    chk("w8 idle", req, 32'h0);
    $display("test w8 done");
  endtask : t_w8
  // frame sync is already inactive, so the stray sample has no frame start
  task automatic t_blank();
    setcfg(PCC_W8, 1'b0, 1'b0);
    u_cam.pix(14'h005A, 1'b0, 1'b0);
    u_cam.frame_start();
    u_cam.pix(14'h0011, 1'b0, 1'b0);
    u_cam.pix(14'h0099, 1'b1, 1'b0);
    u_cam.pix(14'h0022, 1'b0, 1'b0);
    u_cam.pix(14'h0033, 1'b0, 1'b0);
    u_cam.pix(14'h0044, 1'b0, 1'b0);
    take(32'h44332211, "blanked word");
    $display("test blank done");
  endtask : t_blank
  task automatic t_wide();
    logic [15:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = 16'hFFFF >> (16 - wbits[i]);
      setcfg(pcc_width_t'(i + 1), 1'b0, i == 1);
      u_cam.frame_start();
      u_cam.pix(14'h3ABC, 1'b0, 1'b0);
      u_cam.pix(14'h2567, 1'b0, 1'b0);
      take({16'h2567 & m, 16'h3ABC & m}, "wide word");
    end
    $display("test wide done");
  endtask : t_wide
  task automatic t_over();
    int e;
    setcfg(PCC_W14, 1'b0, 1'b0);
    u_cam.frame_start();
    for (int i = 0; i < 14; i++)
      u_cam.pix(14'(16'h0100 + i), 1'b0, 1'b0);
    for (int k = 0; k < 7; k++)
      take({16'(16'h0101 + 2 * k), 16'(16'h0100 + 2 * k)}, "stored word");
    chk("drained", req, 32'h0);
    e = err_seen;
    // nine words with no ack: seven fit, the eighth overruns, the ninth is dropped
    for (int i = 0; i < 18; i++)
      u_cam.pix(14'(16'h0200 + i), 1'b0, 1'b0);
    repeat (8) @(posedge mclk);
    chk("overrun errors", 32'(err_seen - e), 32'h1);
    chk("overrun flush", {req, fwait}, 32'h1);
    $display("test overrun done");
  endtask : t_over
  task automatic t_emb();
    int e;
    setcfg(PCC_W8, 1'b1, 1'b0);
    u_cam.code(codes.frame_start);
    u_cam.code(codes.line_start);
    for (int i = 0; i < 4; i++)
      u_cam.pix({6'h3F, 8'(8'h12 + 8'h22 * i)}, 1'b1, 1'b1);
    u_cam.code(codes.line_end);
    take(32'h78563412, "embedded word");
    // a frame end closes the frame, so a later line start must not reopen capture
    u_cam.code(codes.frame_end);
    u_cam.code(codes.line_start);
    for (int i = 0; i < 4; i++)
      u_cam.pix(14'h0042, 1'b1, 1'b1);
    repeat (4) @(posedge mclk);
    chk("after frame end", req, 32'h0);
    e = err_seen;
    u_cam.code(8'h55);
    repeat (8) @(posedge mclk);
    chk("bad code errors", 32'(err_seen - e), 32'h1);
    chk("bad code wait", {req, fwait}, 32'h1);
    $display("test embedded done");
  endtask : t_emb
  // both sync inputs active low; the frame start is frame sync going high
  task automatic t_pol();
    setcfg(PCC_W8, 1'b0, 1'b0);
    cfg <= '{1'b1, PCC_W8, 1'b0, 1'b0, 1'b0, 1'b0};
    u_cam.pix(14'h0000, 1'b0, 1'b0);
    u_cam.pix(14'h0000, 1'b0, 1'b1);
    u_cam.pix(14'h0011, 1'b1, 1'b1);
    u_cam.pix(14'h0099, 1'b0, 1'b1);
    u_cam.pix(14'h0022, 1'b1, 1'b1);
    u_cam.pix(14'h0077, 1'b1, 1'b0);
    u_cam.pix(14'h0033, 1'b1, 1'b1);
    u_cam.pix(14'h0044, 1'b1, 1'b1);
    take(32'h44332211, "low polarity word");
    $display("test polarity done");
  endtask : t_pol
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
    chk("reset out", {req, fwait}, 32'h1);
    t_w8();
    t_blank();
    t_wide();
    t_over();
    t_emb();
    t_pol();
    results();
  end
  // the run needs about 50 us; five times that marks a hang
  initial
  begin
    #250000;
    fails++;
    results();
  end
endmodule : testbench
